// ---- logic/rbp_packer.sv ----
// raw12 bayer packer: two pixels into three bytes, green/blue phase
// What this block does
// R01: twelve bits out for every pixel; a lone last pixel of a line sends only bits 11:4
// R02: each pixel pair becomes three bytes
// R03: sensor values pass through unaltered
// R04: each value carries its site colour
// R05: byte one holds even pixel bits 11:4
// R06: byte two holds both low nibbles
// R07: byte three holds odd pixel bits 11:4
// R08: even lines: green even, blue odd
// R09: odd lines: red even, green odd
// R10: values unsigned, 0x000 to 0xFFF
// R11: last line byte holds last pixel high
// R12: line and pixel counts restart at zero
// R13: source supplies even pixels per line
`timescale 1ns/1ps
module rbp_packer (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire rbp_pkg::rbp_pixel_t pix_in,
  input wire logic pix_valid,
  output logic pix_ready,
  output rbp_pkg::rbp_byte_t byte_out,
  output logic byte_valid,
  input wire logic byte_ready,
  output logic [`RBP_LINE_CNT_W-1:0] line_index,
  output logic line_odd_pixels
);
  import rbp_pkg::*;

  typedef enum logic [1:0] {
    RBP_ST_EVEN,
    RBP_ST_B1,
    RBP_ST_B2
  } rbp_state_t;

  // colour of a site from line and pixel parity
  function automatic rbp_colour_t site_colour(input logic odd_line, input logic odd_pix);
    if (!odd_line) begin
      site_colour = odd_pix ? RBP_BLUE : RBP_GREEN; // R08
    end else begin
      site_colour = odd_pix ? RBP_GREEN : RBP_RED; // R09
    end
  endfunction

  function automatic logic [`RBP_BYTE_W-1:0] hi_byte(input logic [`RBP_PIX_W-1:0] v);
    hi_byte = v[`RBP_HI_MSB:`RBP_HI_LSB];
  endfunction

  rbp_state_t st_q;
  logic [`RBP_PIX_W-1:0] even_q;
  logic [`RBP_PIX_W-1:0] odd_q;
  logic pair_eol_q;
  logic [`RBP_LINE_CNT_W-1:0] line_q;
  logic [`RBP_PIX_CNT_W-1:0] pos_q;
  logic pix_rdy_q;
  rbp_byte_t byte_q;
  logic bvalid_q;
  logic odd_pix_err_q;

  logic out_free;
  logic take;
  logic odd_line;
  assign out_free = !bvalid_q || byte_ready;
  // the port ready comes from a flop, so accept only on that flop
  assign take = clk_en && pix_rdy_q && pix_valid;
  // a frame start resets line parity even mid-frame
  assign odd_line = pix_in.sof ? 1'b0 : line_q[0]; // R12

  // pair state machine; a byte leaves each of the three states
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_q <= RBP_ST_EVEN;
    end else if (clk_en) begin
      case (st_q)
        RBP_ST_EVEN: begin
          if (take) begin
            st_q <= pix_in.eol ? RBP_ST_EVEN : RBP_ST_B1;
          end
        end
        RBP_ST_B1: begin
          if (take) begin
            st_q <= RBP_ST_B2;
          end
        end
        RBP_ST_B2: begin
          if (out_free) begin
            st_q <= RBP_ST_EVEN;
          end
        end
        default: begin
          st_q <= RBP_ST_EVEN;
        end
      endcase
    end
  end

  // ready only when the output byte can move this cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pix_rdy_q <= 1'b0;
    end else if (clk_en) begin
      pix_rdy_q <= (st_q != RBP_ST_B2) && !take && (!bvalid_q || byte_ready);
    end
  end

  // sample capture, values kept raw
  always_ff @(posedge core_clk) begin
    if (srst) begin
      even_q <= '0;
      odd_q <= '0;
      pair_eol_q <= 1'b0;
    end else if (take) begin
      if (st_q == RBP_ST_EVEN) begin
        even_q <= pix_in.value; // R03
      end else begin
        odd_q <= pix_in.value; // R03
        pair_eol_q <= pix_in.eol;
      end
    end
  end

  // line and pixel position counters
  always_ff @(posedge core_clk) begin
    if (srst) begin
      line_q <= '0;
      pos_q <= '0;
    end else if (take) begin
      if (pix_in.eol) begin
        pos_q <= '0; // R12
        line_q <= (pix_in.sof ? '0 : line_q) + `RBP_LINE_CNT_W'(1); // R12
      end else begin
        pos_q <= (pix_in.sof ? '0 : pos_q) + `RBP_PIX_CNT_W'(1);
        if (pix_in.sof) begin
          line_q <= '0; // R12
        end
      end
    end
  end

  // odd-length line flag; a lone pixel gets only its high byte
  always_ff @(posedge core_clk) begin
    if (srst) begin
      odd_pix_err_q <= 1'b0;
    end else if (take && st_q == RBP_ST_EVEN) begin
      odd_pix_err_q <= pix_in.eol; // R13
    end
  end

  // byte emitter; twelve bits leave per paired pixel over three bytes per pair
  always_ff @(posedge core_clk) begin
    if (srst) begin
      byte_q <= '0;
      bvalid_q <= 1'b0;
    end else if (clk_en) begin
      if (bvalid_q && byte_ready) begin
        bvalid_q <= 1'b0;
      end
      case (st_q)
        RBP_ST_EVEN: begin
          if (take) begin
            byte_q.data <= hi_byte(pix_in.value); // R05 R10
            byte_q.colour <= site_colour(odd_line, 1'b0); // R04
            byte_q.odd_line <= odd_line;
            byte_q.sol <= pix_in.sof || pos_q == '0;
            // a lone last pixel makes this the final byte of its line
            byte_q.eol <= pix_in.eol; // R11
            bvalid_q <= 1'b1; // R01 R02
          end
        end
        RBP_ST_B1: begin
          if (take) begin
            byte_q.data <= {pix_in.value[`RBP_LO_MSB:`RBP_LO_LSB],
                            even_q[`RBP_LO_MSB:`RBP_LO_LSB]}; // R06
            byte_q.colour <= site_colour(line_q[0], 1'b1); // R04
            byte_q.odd_line <= line_q[0];
            byte_q.sol <= 1'b0;
            byte_q.eol <= 1'b0;
            bvalid_q <= 1'b1; // R02
          end
        end
        RBP_ST_B2: begin
          if (out_free) begin
            byte_q.data <= hi_byte(odd_q); // R07
            byte_q.colour <= site_colour(byte_q.odd_line, 1'b1); // R04
            byte_q.sol <= 1'b0;
            byte_q.eol <= pair_eol_q; // R11
            bvalid_q <= 1'b1; // R02
          end
        end
        default: begin
          bvalid_q <= 1'b0;
        end
      endcase
    end
  end

  assign pix_ready = pix_rdy_q;
  assign byte_out = byte_q;
  assign byte_valid = bvalid_q;
  assign line_index = line_q;
  assign line_odd_pixels = odd_pix_err_q;
endmodule

// ---- inc/rbp_cfg.svh ----
// constants for the raw12 bayer pixel packer
`ifndef RBP_CFG_SVH
`define RBP_CFG_SVH
`define RBP_PIX_W 12
`define RBP_BYTE_W 8
`define RBP_HI_MSB 11
`define RBP_HI_LSB 4
`define RBP_LO_MSB 3
`define RBP_LO_LSB 0
`define RBP_PIX_MAX 12'hFFF
`define RBP_LINE_CNT_W 16
`define RBP_PIX_CNT_W 16
`define RBP_GROUP_BYTES 2'h3
`endif

// ---- inc/rbp_pkg.sv ----
// types for the raw12 bayer pixel packer
`include "rbp_cfg.svh"
package rbp_pkg;
  typedef enum logic [1:0] {
    RBP_GREEN,
    RBP_BLUE,
    RBP_RED
  } rbp_colour_t;

  // one sensor sample with its framing marks
  typedef struct packed {
    logic [`RBP_PIX_W-1:0] value;
    logic sof;
    logic eol;
  } rbp_pixel_t;

  // one packed output byte with its tags
  typedef struct packed {
    logic [`RBP_BYTE_W-1:0] data;
    rbp_colour_t colour;
    logic odd_line;
    logic sol;
    logic eol;
  } rbp_byte_t;
endpackage

// ---- tb/rbp_checker.sv ----
// checker on the packer ports
`timescale 1ns/1ps
module rbp_checker (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic clk_en,
  input wire rbp_pkg::rbp_pixel_t pix_in,
  input wire logic pix_valid,
  input wire logic pix_ready,
  input wire rbp_pkg::rbp_byte_t byte_out,
  input wire logic byte_valid,
  input wire logic byte_ready
);
  import rbp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  logic tk, ph_q;
  logic [3:0] lo_q;
  assign tk = clk_en && pix_valid && pix_ready;
  // phase restarts on eol so a short line cannot skew the next
  always_ff @(posedge core_clk) ph_q <= !srst && (tk ? !ph_q && !pix_in.eol : ph_q);
  always_ff @(posedge core_clk) if (tk && !ph_q) lo_q <= pix_in.value[3:0];
  sequence b2_s; tk && ph_q ##1 byte_ready && clk_en; endsequence
  out_hold_a: assert property (byte_valid && !byte_ready |=> byte_valid && $stable(byte_out))
    else $error("lost");
  hi_even_a: assert property (tk && !ph_q |=> byte_out.data == $past(pix_in.value[11:4]))
    else $error("b0");
  lo_nib_a: assert property (tk && ph_q |=> byte_out.data == {$past(pix_in.value[3:0]), lo_q})
    else $error("b1");
  hi_odd_a: assert property (b2_s |=> byte_out.data == $past(pix_in.value[11:4], 2))
    else $error("b2");
  even_col_a: assert property (tk && !ph_q |=> byte_out.colour == (byte_out.odd_line ?
    RBP_RED : RBP_GREEN)) else $error("c0");
  odd_col_a: assert property (b2_s |=> byte_out.colour == (byte_out.odd_line ?
    RBP_GREEN : RBP_BLUE)) else $error("c2");
  line_end_a: assert property (b2_s |=> byte_out.eol == $past(pix_in.eol, 2))
    else $error("eol");
  frame_start_a: assert property (tk && pix_in.sof |=> !byte_out.odd_line)
    else $error("sof");
  cover property (b2_s);
  cover property (byte_valid && !byte_ready);
  cover property (tk && pix_in.sof);
endmodule

// ---- tb/rbp_host.sv ----
// host buffer model, prompt or stalling
`timescale 1ns/1ps
module rbp_host (
  input wire logic core_clk,
  input wire logic slow,
  input wire rbp_pkg::rbp_byte_t byte_out,
  input wire logic byte_valid,
  output logic byte_ready
);
  import rbp_pkg::*;
  rbp_byte_t got[$];
  initial byte_ready = 1'h1;
  always @(posedge core_clk) begin
    if (byte_valid && byte_ready) got.push_back(byte_out);
    byte_ready <= !slow || !byte_ready;
  end
endmodule

// ---- tb/testbench.sv ----
// self-checking bench for the packer
`timescale 1ns/1ps
module testbench;
  import rbp_pkg::*;
  logic core_clk = 1'h0, srst = 1'h1, pix_valid = 1'h0, slow = 1'h0;
  logic pix_ready, byte_valid, byte_ready, odd_pix;
  logic clk_en = 1'h1;
  logic [15:0] line_idx;
  rbp_pixel_t pix_in = '0;
  rbp_byte_t byte_out;
  int mismatches = 0, check_count = 0;
  initial forever #20 core_clk = ~core_clk;
  rbp_packer uut (.core_clk(core_clk), .srst(srst), .clk_en(clk_en), .pix_in(pix_in),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .byte_out(byte_out),
    .byte_valid(byte_valid), .byte_ready(byte_ready), .line_index(line_idx),
    .line_odd_pixels(odd_pix));
  rbp_host host (.core_clk(core_clk), .slow(slow), .byte_out(byte_out),
    .byte_valid(byte_valid), .byte_ready(byte_ready));
  task automatic stop_test;
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(logic [10:0] got, logic [10:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %h %h", $time, got, exp);
    end
  endtask
  task automatic wait_ok(int n);
    if (n >= 60) begin
      mismatches++;
      stop_test();
    end
  endtask
  // four pixels keep the line even, so it ends on a whole group
  task automatic run_line(logic [11:0] px[4], logic sof, logic odd);
    rbp_byte_t g;
    int n;
    for (int i = 0; i < 4; i++) begin
      pix_in <= {px[i], sof && i == 0, i == 3};
      pix_valid <= 1'h1;
      n = 0;
      @(negedge core_clk);
      while (!pix_ready && n < 60) begin
        @(negedge core_clk);
        n++;
      end
      wait_ok(n);
      @(posedge core_clk);
    end
    pix_valid <= 1'h0;
    for (n = 0; host.got.size() < 6 && n < 60; n++) @(posedge core_clk);
    wait_ok(n);
    for (int k = 0; k < 4; k += 2) begin
      g = host.got.pop_front();
      chk({g.data, g.colour, g.eol}, {px[k][11:4], odd ? RBP_RED : RBP_GREEN, 1'h0});
      chk({10'h0, g.sol}, {10'h0, k == 0});
      g = host.got.pop_front();
      chk({g.data, 3'h0}, {px[k+1][3:0], px[k][3:0], 3'h0});
      g = host.got.pop_front();
      chk({g.data, g.colour, g.eol}, {px[k+1][11:4], odd ? RBP_GREEN : RBP_BLUE, k == 2});
    end
    chk(line_idx[10:0], odd ? 11'h2 : 11'h1);
    chk({10'h0, odd_pix}, 11'h0);
  endtask
  // frozen clock enable holds all state; the lone pixel is an odd-length line
  task automatic freeze_hold;
    rbp_byte_t g;
    int n;
    for (n = 0; !pix_ready && n < 60; n++) @(negedge core_clk);
    wait_ok(n);
    @(posedge core_clk);
    clk_en <= 1'h0;
    pix_in <= {12'h9C4, 1'h1, 1'h1};
    pix_valid <= 1'h1;
    repeat (4) @(posedge core_clk);
    chk(11'(host.got.size()), 11'h0);
    chk({10'h0, pix_ready}, 11'h1);
    clk_en <= 1'h1;
    @(posedge core_clk);
    pix_valid <= 1'h0;
    for (n = 0; host.got.size() < 1 && n < 60; n++) @(posedge core_clk);
    wait_ok(n);
    g = host.got.pop_front();
    chk({g.data, g.colour, g.eol}, {8'h9C, RBP_GREEN, 1'h1});
    chk({10'h0, odd_pix}, 11'h1);
    chk(line_idx[10:0], 11'h1);
  endtask
  task automatic even_fast;
    run_line('{12'h000, 12'hFFF, 12'hABC, 12'h123}, 1'h1, 1'h0);
  endtask
  task automatic odd_slow;
    slow <= 1'h1;
    run_line('{12'h5A3, 12'h3C7, 12'hFFF, 12'h000}, 1'h0, 1'h1);
    slow <= 1'h0;
  endtask
  task automatic new_frame;
    run_line('{12'h800, 12'h7FF, 12'h001, 12'hFFE}, 1'h1, 1'h0);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'h0;
    @(posedge core_clk);
    even_fast();
    odd_slow();
    new_frame();
    freeze_hold();
    stop_test();
  end
endmodule
bind rbp_packer rbp_checker chk_i (.core_clk(core_clk), .srst(srst), .clk_en(clk_en),
  .pix_in(pix_in), .pix_valid(pix_valid), .pix_ready(pix_ready), .byte_out(byte_out),
  .byte_valid(byte_valid), .byte_ready(byte_ready));
